// file: verilog/bsav_pkg.sv
// Package: constants for the bus slave address and vector select block
`default_nettype none
package bsav_pkg;
   localparam int ADDR_W = 18;
   localparam int ASW_W = 8;
   localparam int VSW_W = 6;
   localparam int USW_W = 4;
   localparam int ASW_LSB = 4;
   localparam int ASW_MSB = 11;
   localparam int PAGE_LSB = 12;
   localparam int VEC_LSB = 2;
   localparam logic [5:0] PAGE_ONES = 6'h3F;
   localparam logic [ADDR_W-1:0] STD_REG0_ADDR = 18'h3F550;
   localparam logic [ADDR_W-1:0] STD_REG1_ADDR = 18'h3F552;
   localparam logic [7:0] STD_VECTOR = 8'h94;
   localparam logic [1:0] DEFAULT_LEVEL = 2'h1;
   localparam int DMA_WORD_NS = 1000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int DMA_WORD_CYC = DMA_WORD_NS / CLK_PERIOD_NS;
   localparam int SAMPLE_CYC = 4;
   typedef enum logic [1:0] {BSAV_IDLE, BSAV_REQ, BSAV_HOLD} bsav_dma_t;
endpackage : bsav_pkg
`default_nettype wire

// file: verilog/bsav_sync.sv
// Two-stage synchroniser for a bundle of slow switch levels
`default_nettype none
module bsav_sync #(parameter int W = 8)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         meta_q <= '0;
         dout <= '0;
      end
      else if (ce)
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule : bsav_sync
`default_nettype wire

// file: verilog/bsav_top.sv
// Address decode, vector select, priority chain and DMA pacing
`default_nettype none
// Summary of operation
// - Match address bits 4..11 against eight address switches.
// - Address switch on gives bit zero, off gives bit one.
// - Units two to four shift the register pair by an offset.
// - Standard switches answer at 772520 and 772522 octal.
// - Vector bits 2..7 come from six vector switches.
// - Vector bits 0 and 1 are always zero.
// - Vector switch on gives one, off gives zero.
// - Standard vector switches give vector 224 octal.
// - Unit select never alters the vector.
// - Second drive vector comes from a separate six-switch group.
// - First drive vector uses the standard vector switches.
// - Grant daisy chain position sets interrupt priority; nearer boards win.
// - DMA holds bus about one microsecond per word.
// - Word is held buffered so late grants cause no data loss.
// - One of four units, offsets 0, 4, 10, 14 octal.
// - Interrupt request on one selectable level 4..7, default 5.
module bsav_top
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [17:0] bus_addr,
   input wire logic bus_sel,
   input wire logic [7:0] address_switch_group,
   input wire logic [5:0] vector_switch_group,
   input wire logic [5:0] second_vector_switch_group,
   input wire logic [3:0] unit_select_switch_group,
   input wire logic two_drive_en,
   input wire logic [1:0] level_sel,
   input wire logic level_sel_valid,
   input wire logic irq_drive0,
   input wire logic irq_drive1,
   input wire logic grant_in,
   input wire logic dma_word_req,
   output logic hit_q,
   output logic reg_sel_q,
   output logic [7:0] vector_q,
   output logic [3:0] bus_req_q,
   output logic grant_out_q,
   output logic grant_taken_q,
   output logic bus_busy_q,
   output logic dma_done_q,
   output logic cfg_valid_q
);
   logic [7:0] asw_s;
   logic [17:0] addr_s;
   logic [5:0] vsw_s;
   logic [5:0] vsw2_s;
   logic [3:0] usw_s;
   logic [1:0] lvl_s;
   logic [1:0] misc_s;
   logic [2:0] grant_s;
   logic [7:0] base_q;
   logic [5:0] vec0_q;
   logic [5:0] vec1_q;
   logic [1:0] unit_q;
   logic [1:0] level_q;
   logic two_q;
   logic [2:0] samp_cnt_q;
   logic vec_owner_q;
   logic irq_pend;
   logic [7:0] dma_cnt_q;
   bsav_pkg::bsav_dma_t dma_st_q;

   bsav_sync #(.W(8)) u_sa (.clk(clk), .srst(srst), .ce(ce), .din(address_switch_group),
      .dout(asw_s));
   bsav_sync #(.W(6)) u_sv (.clk(clk), .srst(srst), .ce(ce), .din(vector_switch_group),
      .dout(vsw_s));
   bsav_sync #(.W(6)) u_sv2 (.clk(clk), .srst(srst), .ce(ce),
      .din(second_vector_switch_group), .dout(vsw2_s));
   bsav_sync #(.W(4)) u_su (.clk(clk), .srst(srst), .ce(ce), .din(unit_select_switch_group),
      .dout(usw_s));
   bsav_sync #(.W(2)) u_sl (.clk(clk), .srst(srst), .ce(ce), .din(level_sel), .dout(lvl_s));
   bsav_sync #(.W(2)) u_sm (.clk(clk), .srst(srst), .ce(ce),
      .din({two_drive_en, level_sel_valid}), .dout(misc_s));
   bsav_sync #(.W(3)) u_sg (.clk(clk), .srst(srst), .ce(ce),
      .din({grant_in, dma_word_req, bus_sel}), .dout(grant_s));
   // Address rides the same two stages as its qualifier, so both stay aligned
   bsav_sync #(.W(18)) u_sb (.clk(clk), .srst(srst), .ce(ce), .din(bus_addr), .dout(addr_s));

   // Unit number from one-hot switches; invalid patterns fall back to unit 0
   wire [1:0] unit_dec = (usw_s == 4'h2) ? 2'h1 :
                         (usw_s == 4'h4) ? 2'h2 :
                         (usw_s == 4'h8) ? 2'h3 : 2'h0;
   wire [7:0] pair_base = ~asw_s;

   // Switches caught once, a few cycles after reset so the synchronisers settle
   wire sample_now = (samp_cnt_q == 3'(bsav_pkg::SAMPLE_CYC)) && !cfg_valid_q;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         samp_cnt_q <= '0;
         cfg_valid_q <= 1'b0;
         base_q <= 8'hFF;
         vec0_q <= '0;
         vec1_q <= '0;
         unit_q <= '0;
         level_q <= bsav_pkg::DEFAULT_LEVEL;
         two_q <= 1'b0;
      end
      else if (ce && !cfg_valid_q)
      begin
         samp_cnt_q <= samp_cnt_q + 3'h1;
         if (sample_now)
         begin
            cfg_valid_q <= 1'b1;
            base_q <= pair_base;
            vec0_q <= vsw_s;
            vec1_q <= vsw2_s;
            unit_q <= unit_dec;
            level_q <= misc_s[0] ? lvl_s : bsav_pkg::DEFAULT_LEVEL;
            two_q <= misc_s[1];
         end
      end
   end

   // Offset in 2-word steps per unit: address bits 3:2 carry the unit
   wire [17:0] eff_addr = grant_s[0] ? addr_s : 18'h0;
   wire page_ok = eff_addr[17:bsav_pkg::PAGE_LSB] == bsav_pkg::PAGE_ONES;
   wire base_ok = eff_addr[bsav_pkg::ASW_MSB:bsav_pkg::ASW_LSB] == base_q;
   wire unit_ok = eff_addr[3:2] == unit_q;
   wire addr_hit = cfg_valid_q && grant_s[0] && page_ok && base_ok && unit_ok &&
                   !eff_addr[0];

   // Vector select never looks at the unit
   wire [5:0] vec_bits = (two_q && vec_owner_q) ? vec1_q : vec0_q;
   wire vec_owner_d = two_q && irq_drive1 && !irq_drive0;
   assign irq_pend = irq_drive0 || (two_q && irq_drive1);
   wire grant_mine = grant_s[2] && irq_pend && cfg_valid_q;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         hit_q <= 1'b0;
         reg_sel_q <= 1'b0;
         vector_q <= '0;
         vec_owner_q <= 1'b0;
         bus_req_q <= '0;
         grant_out_q <= 1'b0;
         grant_taken_q <= 1'b0;
      end
      else if (ce)
      begin
         hit_q <= addr_hit;
         reg_sel_q <= eff_addr[1];
         if (!grant_taken_q)
            vec_owner_q <= vec_owner_d;
         vector_q <= {vec_bits, 2'h0};
         bus_req_q <= (irq_pend && cfg_valid_q) ? (4'h1 << level_q) : 4'h0;
         // Pass the grant downstream unless an interrupt here takes it; a DMA request here does not stop it
         grant_out_q <= grant_s[2] && !grant_mine;
         grant_taken_q <= grant_mine;
      end
   end

   // DMA pacing: hold mastership a fixed time per word; the word is already latched
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         dma_st_q <= bsav_pkg::BSAV_IDLE;
         dma_cnt_q <= '0;
         bus_busy_q <= 1'b0;
         dma_done_q <= 1'b0;
      end
      else if (ce)
      begin
         dma_done_q <= 1'b0;
         case (dma_st_q)
            bsav_pkg::BSAV_IDLE:
               if (grant_s[1])
                  dma_st_q <= bsav_pkg::BSAV_REQ;
            bsav_pkg::BSAV_REQ:
               if (grant_s[2])
               begin
                  dma_st_q <= bsav_pkg::BSAV_HOLD;
                  bus_busy_q <= 1'b1;
                  dma_cnt_q <= 8'(bsav_pkg::DMA_WORD_CYC - 1);
               end
            bsav_pkg::BSAV_HOLD:
               if (dma_cnt_q == 8'h00)
               begin
                  dma_st_q <= bsav_pkg::BSAV_IDLE;
                  bus_busy_q <= 1'b0;
                  dma_done_q <= 1'b1;
               end
               else
                  dma_cnt_q <= dma_cnt_q - 8'h01;
            default:
               dma_st_q <= bsav_pkg::BSAV_IDLE;
         endcase
      end
   end

   // Vector is one switch group with two zero low bits, whatever the unit
   std_vec_a: assert property (@(posedge clk) disable iff (srst)
      vector_q == 8'h00 || vector_q == {vec0_q, 2'h0} || vector_q == {vec1_q, 2'h0})
      else $error("vector not built from a switch group");
   page_hit_a: assert property (@(posedge clk) disable iff (srst)
      hit_q |-> $past(eff_addr[17:12]) == bsav_pkg::PAGE_ONES && !$past(eff_addr[0]))
      else $error("hit outside io page");
   base_hit_a: assert property (@(posedge clk) disable iff (srst)
      hit_q |-> $past(eff_addr[11:4]) == base_q)
      else $error("hit with wrong base");
   unit_hit_a: assert property (@(posedge clk) disable iff (srst)
      hit_q |-> $past(eff_addr[3:2]) == unit_q)
      else $error("hit with wrong unit");
   one_level_a: assert property (@(posedge clk) disable iff (srst)
      $onehot0(bus_req_q))
      else $error("more than one request level");
   grant_pass_a: assert property (@(posedge clk) disable iff (srst)
      !(grant_out_q && grant_taken_q))
      else $error("grant both kept and passed");
   dma_hold_a: assert property (@(posedge clk) disable iff (srst)
      $rose(bus_busy_q) && ce |-> bus_busy_q [*8])
      else $error("mastership dropped early");
   vec_src_a: assert property (@(posedge clk) disable iff (srst)
      (ce && !two_q && cfg_valid_q) |=> vector_q[7:2] == vec0_q)
      else $error("first drive vector wrong source");
   hit_c: cover property (@(posedge clk) hit_q && reg_sel_q);
   grant_c: cover property (@(posedge clk) grant_taken_q);
   dma_c: cover property (@(posedge clk) dma_done_q);
   freeze_c: cover property (@(posedge clk) bus_busy_q && !ce);
endmodule : bsav_top
`default_nettype wire

// file: bench/bsav_host_model.sv
// Host side of the backplane: hands out the daisy grant after a set delay
`default_nettype none
module bsav_host_model
(
   input wire logic clk,
   input wire logic srst,
   input wire logic req,
   input wire logic [7:0] delay,
   output logic grant_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wait_q;
   // Large delay stands for a busy bus, so late grants can be tried
   always_ff @(posedge clk)
   begin
      if (srst || !req)
      begin
         wait_q <= 8'h00;
         grant_in <= 1'b0;
      end
      else if (wait_q >= delay)
         grant_in <= 1'b1;
      else
         wait_q <= wait_q + 8'h01;
   end
endmodule : bsav_host_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for address decode, vector select, grant and DMA pacing
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, srst = 1'b1, sel = 1'b0, two = 1'b0, lok = 1'b0;
   logic irq0 = 1'b0, irq1 = 1'b0, dreq = 1'b0, xreq = 1'b0, ce = 1'b1;
   logic [17:0] addr = 18'h00000;
   // Standard address switches: on-switches clear bits 5, 7, 9 and 11
   logic [7:0] asw = 8'hAA, dly = 8'hFF;
   logic [5:0] vsw = 6'h25, vsw2 = 6'h00;
   logic [3:0] usw = 4'h1, breq;
   logic [1:0] lvl = 2'h0;
   logic gin, hit, rsel, gout, gtk, busy, done, cfg;
   logic [7:0] vec;
   int err_total = 0, total_checks = 0;
   always #5 clk = ~clk;
   bsav_top i_dut (.clk(clk), .srst(srst), .ce(ce), .bus_addr(addr), .bus_sel(sel),
      .address_switch_group(asw), .vector_switch_group(vsw),
      .second_vector_switch_group(vsw2), .unit_select_switch_group(usw),
      .two_drive_en(two), .level_sel(lvl), .level_sel_valid(lok), .irq_drive0(irq0),
      .irq_drive1(irq1), .grant_in(gin), .dma_word_req(dreq), .hit_q(hit), .reg_sel_q(rsel),
      .vector_q(vec), .bus_req_q(breq), .grant_out_q(gout), .grant_taken_q(gtk),
      .bus_busy_q(busy), .dma_done_q(done), .cfg_valid_q(cfg));
   bsav_host_model i_host (.clk(clk), .srst(srst), .req(|breq || dreq || xreq),
      .delay(dly), .grant_in(gin));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic results;
      if (err_total == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   // Switches are only taken at reset, so each setting needs a fresh boot
   task automatic boot;
      srst = 1'b1;
      cyc(5);
      chk("cfg", 8'h00, {7'h0, cfg});
      srst = 1'b0;
      cyc(6);
      chk("cfg", 8'h01, {7'h0, cfg});
   endtask : boot
   task automatic probe(input logic [17:0] a, input logic eh, input logic er);
      addr = a;
      sel = 1'b1;
      cyc(4);
      chk("hit", {7'h0, eh}, {7'h0, hit});
      if (eh)
         chk("reg_sel", {7'h0, er}, {7'h0, rsel});
      sel = 1'b0;
      cyc(4);
   endtask : probe
   task automatic t_addr;
      boot;
      probe(bsav_pkg::STD_REG0_ADDR, 1'b1, 1'b0);
      probe(bsav_pkg::STD_REG1_ADDR, 1'b1, 1'b1);
      probe(18'h3F551, 1'b0, 1'b0);
      probe(18'h1F550, 1'b0, 1'b0);
      probe(18'h3F560, 1'b0, 1'b0);
      asw = 8'h00;
      boot;
      probe(18'h3FFF0, 1'b1, 1'b0);
      asw = 8'hFF;
      boot;
      probe(18'h3F002, 1'b1, 1'b1);
      asw = 8'hAA;
   endtask : t_addr
   task automatic t_unit;
      for (int i = 0; i < 5; i++)
      begin
         usw = 4'h1 << (i % 4);
         lvl = 2'(i);
         lok = (i < 4);
         boot;
         probe(18'h3F550 + 18'(4 * (i % 4)), 1'b1, 1'b0);
         probe(18'h3F552 + 18'(4 * (i % 4)), 1'b1, 1'b1);
         probe(18'h3F550 + 18'(4 * ((i + 1) % 4)), 1'b0, 1'b0);
         irq0 = 1'b1;
         cyc(6);
         chk("bus_req", (i < 4) ? 8'(4'h1 << i) : 8'h02, {4'h0, breq});
         chk("vector", bsav_pkg::STD_VECTOR, vec);
         irq0 = 1'b0;
         cyc(8);
      end
   endtask : t_unit
   task automatic t_vec;
      two = 1'b1;
      vsw2 = 6'h3F;
      boot;
      irq1 = 1'b1;
      cyc(6);
      chk("vector", 8'hFC, vec);
      irq0 = 1'b1;
      cyc(6);
      chk("vector", 8'h94, vec);
      irq1 = 1'b0;
      cyc(6);
      chk("vector", 8'h94, vec);
      irq0 = 1'b0;
      cyc(8);
   endtask : t_vec
   task automatic t_grant;
      dly = 8'h03;
      irq0 = 1'b1;
      for (int k = 0; k < 40 && gtk !== 1'b1; k++)
         cyc(1);
      chk("taken", 8'h01, {7'h0, gtk});
      chk("passed", 8'h00, {7'h0, gout});
      irq0 = 1'b0;
      cyc(10);
      xreq = 1'b1;
      for (int k = 0; k < 40 && gout !== 1'b1; k++)
         cyc(1);
      chk("passed", 8'h01, {7'h0, gout});
      chk("taken", 8'h00, {7'h0, gtk});
      xreq = 1'b0;
      cyc(10);
   endtask : t_grant
   // A nonzero f holds the clock enable low for f cycles inside the hold
   task automatic t_dma(input logic [7:0] d, input int f);
      int n;
      n = 0;
      dly = d;
      dreq = 1'b1;
      for (int k = 0; k < 400 && busy !== 1'b1; k++)
         cyc(1);
      dreq = 1'b0;
      if (f > 0)
      begin
         ce = 1'b0;
         cyc(f);
         chk("frozen", 8'h01, {7'h0, busy});
         ce = 1'b1;
      end
      while (busy === 1'b1 && n < 300)
      begin
         cyc(1);
         n++;
      end
      chk("hold", 8'(bsav_pkg::DMA_WORD_CYC), 8'(n));
      chk("done", 8'h01, {7'h0, done});
      cyc(1);
      chk("done", 8'h00, {7'h0, done});
      cyc(10);
   endtask : t_dma
   initial
   begin
      t_addr;
      t_unit;
      t_vec;
      t_grant;
      t_dma(8'h01, 0);
      t_dma(8'h3C, 0);
      t_dma(8'h02, 20);
      results;
   end
   initial
   begin
      repeat (30000) @(posedge clk);
      err_total++;
      results;
   end
endmodule : testbench
`default_nettype wire
